// ### core/ctrf_filter.sv
// Upper-node request filter with set and clear ports
module ctrf_filter
  import ctrf_pkg::*;
(
  // Clock and reset
  input  wire logic   i_clk,
  input  wire logic   i_rst,
  // Register carrier
  ctrf_reg_if.filter  bus
);

  typedef struct packed {
    logic [31:0] bits;
  } ctrf_filter_s;

  ctrf_filter_s st;
  ctrf_filter_s next_st;

  // ========================================================================
  // Next state
  always_comb begin
    next_st = st;
    if (bus.set_wr) begin
      next_st.bits = st.bits | bus.wdata;
    end else if (bus.clr_wr) begin
      next_st.bits = st.bits & ~bus.wdata;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st <= ctrf_filter_s'(FILTER_RST);
    end else begin
      st <= next_st;
    end
  end

  assign bus.filter_val = st.bits;

endmodule : ctrf_filter

// ### core/ctrf_pkg.sv
// Constants, types and register map of the cycle timer and request filter
// ==========================================================================
// Operation
// - As cycle master, send the current timer value in each cycle start.
// - Not cycle master: load the whole timer from each received cycle start.
// - Without cycle starts, keep counting locally while counting is enabled.
// - Tick field, bits 11-0, counts local ticks modulo 3072.
// - Cycle field, bits 24-12, counts tick rollovers modulo 8000.
// - Seconds field, bits 31-25, counts cycle rollovers modulo 128.
// - With external 8 kHz source, each external tick clears the tick field.
// - Timer is read/write at F0h and hardware also updates it.
// - Filtered context request from a node with bit zero: no ack, no queue.
// - Per-node bit comparison applies only to sources on the local bus.
// - Remote-bus requests accepted only while filter bit 31 is set.
// - Filter bit n enables local node n plus 32, nodes 32 to 62.
// - Set port at 100h, clear port at 104h; both read the filter.
// - Filter resets to all zeros, rejecting upper and remote nodes.
package ctrf_pkg;

  // ========================================================================
  // Register map
  localparam logic [11:0] ADDR_TIMER  = 12'h0f0;
  localparam logic [11:0] ADDR_CTRL   = 12'h0f8;
  localparam logic [11:0] ADDR_SET    = 12'h100;
  localparam logic [11:0] ADDR_CLR    = 12'h104;

  // ========================================================================
  // Timer fields and wrap points
  typedef struct packed {
    logic [6:0]  seconds;
    logic [12:0] cycles;
    logic [11:0] ticks;
  } ctrf_time_s;

  localparam logic [12:0] TICK_LAST   = 13'h0bff;
  localparam logic [12:0] CYCLE_LAST  = 13'h1f3f;
  localparam logic [12:0] SEC_LAST    = 13'h007f;
  localparam logic [31:0] TIMER_RST   = 32'h0000_0000;

  // ========================================================================
  // Control register fields
  typedef struct packed {
    logic ext_mode;
    logic count_en;
    logic master;
  } ctrf_ctrl_s;

  localparam logic [2:0]  CTRL_RST    = 3'h0;
  localparam logic [28:0] CTRL_PAD    = 29'h0;

  // ========================================================================
  // Filter layout
  localparam logic [31:0] FILTER_RST  = 32'h0000_0000;
  localparam logic [4:0]  ALL_BUS_BIT = 5'h1f;
  localparam logic [5:0]  NODE_FIRST  = 6'h20;
  localparam logic [5:0]  NODE_LAST   = 6'h3e;
  localparam logic [31:0] RDATA_IDLE  = 32'h0000_0000;

  typedef enum logic [2:0] {
    SEL_NONE  = 3'h0,
    SEL_TIMER = 3'h1,
    SEL_CTRL  = 3'h2,
    SEL_SET   = 3'h3,
    SEL_CLR   = 3'h4
  } ctrf_sel_e;

endpackage : ctrf_pkg

// ### core/ctrf_reg_if.sv
// Internal carrier between the top and its timer and filter
interface ctrf_reg_if;
  import ctrf_pkg::*;
  logic        timer_wr;
  logic        set_wr;
  logic        clr_wr;
  logic [31:0] wdata;
  logic        cs_load;
  logic [31:0] cs_data;
  logic        tick_24m;
  logic        ext_tick;
  ctrf_ctrl_s  ctrl;
  ctrf_time_s  time_val;
  logic [31:0] filter_val;

  modport top    (output timer_wr, set_wr, clr_wr, wdata, cs_load, cs_data,
                  tick_24m, ext_tick, ctrl, input time_val, filter_val);
  modport timer  (input timer_wr, wdata, cs_load, cs_data, tick_24m, ext_tick,
                  ctrl, output time_val);
  modport filter (input set_wr, clr_wr, wdata, output filter_val);
endinterface : ctrf_reg_if

// ### core/ctrf_timer.sv
// Bus cycle timer with tick, cycle and seconds fields
module ctrf_timer
  import ctrf_pkg::*;
(
  // Clock and reset
  input  wire logic   i_clk,
  input  wire logic   i_rst,
  // Register carrier
  ctrf_reg_if.timer   bus
);

  typedef struct packed {
    ctrf_time_s tm;
  } ctrf_timer_s;

  ctrf_timer_s st;
  ctrf_timer_s next_st;
  logic        cycle_step;

  function automatic logic [12:0] inc_mod(input logic [12:0] v, input logic [12:0] last);
    inc_mod = (v == last) ? 13'h0 : 13'(v + 13'h1);
  endfunction : inc_mod

  // ========================================================================
  // Next state
  always_comb begin
    next_st    = st;
    cycle_step = 1'b0;
    if (bus.timer_wr) begin
      next_st.tm = ctrf_time_s'(bus.wdata);
    end else if (bus.cs_load && !bus.ctrl.master) begin
      next_st.tm = ctrf_time_s'(bus.cs_data);
    end else if (bus.ctrl.count_en) begin
      if (bus.tick_24m) begin
        next_st.tm.ticks = 12'(inc_mod({1'b0, st.tm.ticks}, TICK_LAST));
        cycle_step       = !bus.ctrl.ext_mode && ({1'b0, st.tm.ticks} == TICK_LAST);
      end
      if (bus.ctrl.ext_mode && bus.ext_tick) begin
        next_st.tm.ticks = '0;
        cycle_step       = 1'b1;
      end
      if (cycle_step) begin
        next_st.tm.cycles = inc_mod(st.tm.cycles, CYCLE_LAST);
        if (st.tm.cycles == CYCLE_LAST) begin
          next_st.tm.seconds = 7'(inc_mod({6'h0, st.tm.seconds}, SEC_LAST));
        end
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st <= ctrf_timer_s'(TIMER_RST);
    end else begin
      st <= next_st;
    end
  end

  assign bus.time_val = st.tm;

endmodule : ctrf_timer

// ### core/ctrf_top.sv
// Top of the cycle timer and asynchronous request filter
module ctrf_top
  import ctrf_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Register port
  input  wire logic [11:0] i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  // Cycle timing
  input  wire logic        i_tick_24m,
  input  wire logic        i_ext_tick_8k,
  // Cycle start messages
  input  wire logic        i_cs_rx_valid,
  input  wire logic [31:0] i_cs_rx_data,
  input  wire logic        i_cs_tx_req,
  output logic             o_cs_tx_valid,
  output logic      [31:0] o_cs_tx_data,
  // Request check
  input  wire logic        i_req_valid,
  input  wire logic        i_req_ctx,
  input  wire logic        i_req_local_bus,
  input  wire logic [5:0]  i_req_node,
  input  wire logic        i_req_low_accept,
  output logic             o_req_done,
  output logic             o_req_accept
);

  typedef struct packed {
    ctrf_ctrl_s  ctrl;
    logic [31:0] rdata;
    logic        tx_valid;
    logic [31:0] tx_data;
    logic        req_done;
    logic        req_accept;
  } ctrf_top_s;

  ctrf_top_s  st;
  ctrf_top_s  next_st;
  ctrf_sel_e  wr_sel;
  ctrf_sel_e  rd_sel;
  ctrf_reg_if bus ();

  // ========================================================================
  // Address decode
  function automatic ctrf_sel_e decode(input logic [11:0] a);
    if (a == ADDR_TIMER) begin
      decode = SEL_TIMER;
    end else if (a == ADDR_CTRL) begin
      decode = SEL_CTRL;
    end else if (a == ADDR_SET) begin
      decode = SEL_SET;
    end else if (a == ADDR_CLR) begin
      decode = SEL_CLR;
    end else begin
      decode = SEL_NONE;
    end
  endfunction : decode

  assign wr_sel = i_wr ? decode(i_addr) : SEL_NONE;
  assign rd_sel = i_rd ? decode(i_addr) : SEL_NONE;

  // ========================================================================
  // Carrier drive
  assign bus.timer_wr = (wr_sel == SEL_TIMER);
  assign bus.set_wr   = (wr_sel == SEL_SET);
  assign bus.clr_wr   = (wr_sel == SEL_CLR);
  assign bus.wdata    = i_wdata;
  assign bus.cs_load  = i_cs_rx_valid;
  assign bus.cs_data  = i_cs_rx_data;
  assign bus.tick_24m = i_tick_24m;
  assign bus.ext_tick = i_ext_tick_8k;
  assign bus.ctrl     = st.ctrl;

  // ========================================================================
  // Submodules
  ctrf_timer u_timer (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .bus   (bus.timer)
  );

  ctrf_filter u_filter (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .bus   (bus.filter)
  );

  // ========================================================================
  // Next state
  always_comb begin
    next_st          = st;
    next_st.rdata    = RDATA_IDLE;
    next_st.tx_valid = 1'b0;
    next_st.req_done = 1'b0;
    if (wr_sel == SEL_CTRL) begin
      next_st.ctrl = ctrf_ctrl_s'(i_wdata[2:0]);
    end
    case (rd_sel)
      SEL_TIMER: begin
        next_st.rdata = bus.time_val;
      end
      SEL_CTRL: begin
        next_st.rdata = {CTRL_PAD, st.ctrl};
      end
      SEL_SET, SEL_CLR: begin
        next_st.rdata = bus.filter_val;
      end
      default: begin
        next_st.rdata = RDATA_IDLE;
      end
    endcase
    if (i_cs_tx_req && st.ctrl.master) begin
      next_st.tx_valid = 1'b1;
      next_st.tx_data  = bus.time_val;
    end
    if (i_req_valid) begin
      next_st.req_done = 1'b1;
      if (!i_req_ctx) begin
        next_st.req_accept = 1'b1;
      end else if (!i_req_local_bus) begin
        next_st.req_accept = bus.filter_val[ALL_BUS_BIT];
      end else if (i_req_node < NODE_FIRST) begin
        next_st.req_accept = i_req_low_accept;
      end else if (i_req_node <= NODE_LAST) begin
        next_st.req_accept = bus.filter_val[i_req_node[4:0]];
      end else begin
        next_st.req_accept = 1'b0;
      end
    end else begin
      next_st.req_accept = 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st            <= '0;
      st.ctrl       <= ctrf_ctrl_s'(CTRL_RST);
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata       = st.rdata;
  assign o_cs_tx_valid = st.tx_valid;
  assign o_cs_tx_data  = st.tx_data;
  assign o_req_done    = st.req_done;
  assign o_req_accept  = st.req_accept;

  // ========================================================================
  // Checks
  logic quiet;
  assign quiet = !bus.timer_wr && !(i_cs_rx_valid && !st.ctrl.master);

  sequence s_tick_step;
    quiet && st.ctrl.count_en && !st.ctrl.ext_mode && i_tick_24m;
  endsequence

  sequence s_tick_wrap;
    s_tick_step ##0 ({1'b0, bus.time_val.ticks} == TICK_LAST);
  endsequence

  property p_tx_value;
    @(posedge i_clk) disable iff (i_rst)
    (i_cs_tx_req && st.ctrl.master) |=> (o_cs_tx_valid && o_cs_tx_data == $past(bus.time_val));
  endproperty
  a_tx_value: assert property (p_tx_value) else $error("cycle start payload wrong");

  property p_rx_load;
    @(posedge i_clk) disable iff (i_rst)
    (i_cs_rx_valid && !st.ctrl.master && !bus.timer_wr) |=> (bus.time_val == $past(i_cs_rx_data));
  endproperty
  a_rx_load: assert property (p_rx_load) else $error("cycle start not loaded");

  property p_hold;
    @(posedge i_clk) disable iff (i_rst)
    (quiet && !st.ctrl.count_en) |=> $stable(bus.time_val);
  endproperty
  a_hold: assert property (p_hold) else $error("timer moved while idle");

  property p_tick_inc;
    @(posedge i_clk) disable iff (i_rst)
    (s_tick_step ##0 ({1'b0, bus.time_val.ticks} != TICK_LAST))
      |=> (bus.time_val.ticks == 12'($past(bus.time_val.ticks) + 12'h1));
  endproperty
  a_tick_inc: assert property (p_tick_inc) else $error("tick did not advance");

  property p_tick_wrap;
    @(posedge i_clk) disable iff (i_rst)
    s_tick_wrap |=> (bus.time_val.ticks == 12'h0);
  endproperty
  a_tick_wrap: assert property (p_tick_wrap) else $error("tick did not wrap");

  property p_cycle_step;
    @(posedge i_clk) disable iff (i_rst)
    (s_tick_wrap ##0 (bus.time_val.cycles != CYCLE_LAST))
      |=> (bus.time_val.cycles == 13'($past(bus.time_val.cycles) + 13'h1));
  endproperty
  a_cycle_step: assert property (p_cycle_step) else $error("cycle did not advance");

  property p_cycle_wrap;
    @(posedge i_clk) disable iff (i_rst)
    (s_tick_wrap ##0 (bus.time_val.cycles == CYCLE_LAST))
      |=> (bus.time_val.cycles == 13'h0 && bus.time_val.seconds != $past(bus.time_val.seconds));
  endproperty
  a_cycle_wrap: assert property (p_cycle_wrap) else $error("cycle did not wrap");

  property p_sec_wrap;
    @(posedge i_clk) disable iff (i_rst)
    (s_tick_wrap ##0 (bus.time_val.cycles == CYCLE_LAST)
      ##0 ({6'h0, bus.time_val.seconds} == SEC_LAST)) |=> (bus.time_val.seconds == 7'h0);
  endproperty
  a_sec_wrap: assert property (p_sec_wrap) else $error("seconds did not wrap");

  property p_ext_clear;
    @(posedge i_clk) disable iff (i_rst)
    (quiet && st.ctrl.count_en && st.ctrl.ext_mode && i_ext_tick_8k) |=> (bus.time_val.ticks == 12'h0);
  endproperty
  a_ext_clear: assert property (p_ext_clear) else $error("external tick did not clear");

  property p_timer_rw;
    @(posedge i_clk) disable iff (i_rst)
    (i_wr && i_addr == ADDR_TIMER) ##1 (i_rd && i_addr == ADDR_TIMER)
      |=> (o_rdata == $past(i_wdata, 2));
  endproperty
  a_timer_rw: assert property (p_timer_rw) else $error("timer write not read back");

  property p_local_reject;
    @(posedge i_clk) disable iff (i_rst)
    (i_req_valid && i_req_ctx && i_req_local_bus && i_req_node >= NODE_FIRST
      && i_req_node <= NODE_LAST && !bus.filter_val[i_req_node[4:0]])
      |=> (o_req_done && !o_req_accept);
  endproperty
  a_local_reject: assert property (p_local_reject) else $error("filtered node accepted");

  property p_low_pass;
    @(posedge i_clk) disable iff (i_rst)
    (i_req_valid && i_req_ctx && i_req_local_bus && i_req_node < NODE_FIRST)
      |=> (o_req_accept == $past(i_req_low_accept));
  endproperty
  a_low_pass: assert property (p_low_pass) else $error("lower node not passed");

  property p_remote;
    @(posedge i_clk) disable iff (i_rst)
    (i_req_valid && i_req_ctx && !i_req_local_bus)
      |=> (o_req_done && o_req_accept == $past(bus.filter_val[ALL_BUS_BIT]));
  endproperty
  a_remote: assert property (p_remote) else $error("remote gate wrong");

  property p_node_map;
    @(posedge i_clk) disable iff (i_rst)
    (i_req_valid && i_req_ctx && i_req_local_bus && i_req_node >= NODE_FIRST
      && i_req_node <= NODE_LAST && bus.filter_val[i_req_node[4:0]]) |=> o_req_accept;
  endproperty
  a_node_map: assert property (p_node_map) else $error("enabled node refused");

  property p_port_read;
    @(posedge i_clk) disable iff (i_rst)
    (i_rd && (i_addr == ADDR_SET || i_addr == ADDR_CLR)) |=> (o_rdata == $past(bus.filter_val));
  endproperty
  a_port_read: assert property (p_port_read) else $error("filter read wrong");

  property p_reset_zero;
    @(posedge i_clk)
    $fell(i_rst) |-> (bus.filter_val == FILTER_RST);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("filter not zero after reset");

  property p_set_bits;
    @(posedge i_clk) disable iff (i_rst)
    (i_wr && i_addr == ADDR_SET) |=> (bus.filter_val == ($past(bus.filter_val) | $past(i_wdata)));
  endproperty
  a_set_bits: assert property (p_set_bits) else $error("set port wrong");

  property p_clr_bits;
    @(posedge i_clk) disable iff (i_rst)
    (i_wr && i_addr == ADDR_CLR) |=> (bus.filter_val == ($past(bus.filter_val) & ~$past(i_wdata)));
  endproperty
  a_clr_bits: assert property (p_clr_bits) else $error("clear port wrong");

  property p_rdata_idle;
    @(posedge i_clk) disable iff (i_rst)
    !i_rd |=> (o_rdata == RDATA_IDLE);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

  property p_timer_read;
    @(posedge i_clk) disable iff (i_rst)
    (i_rd && i_addr == ADDR_TIMER) |=> (o_rdata == $past(bus.time_val));
  endproperty
  a_timer_read: assert property (p_timer_read) else $error("timer read wrong");

  property p_sw_write;
    @(posedge i_clk) disable iff (i_rst)
    (i_wr && i_addr == ADDR_TIMER) |=> (bus.time_val == $past(i_wdata));
  endproperty
  a_sw_write: assert property (p_sw_write) else $error("timer write lost");

  property p_tx_quiet;
    @(posedge i_clk) disable iff (i_rst)
    !(i_cs_tx_req && st.ctrl.master) |=> !o_cs_tx_valid;
  endproperty
  a_tx_quiet: assert property (p_tx_quiet) else $error("cycle start sent unasked");

  property p_tx_hold;
    @(posedge i_clk) disable iff (i_rst)
    !(i_cs_tx_req && st.ctrl.master) |=> $stable(o_cs_tx_data);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("cycle start payload moved");

  property p_req_idle;
    @(posedge i_clk) disable iff (i_rst)
    !i_req_valid |=> (!o_req_done && !o_req_accept);
  endproperty
  a_req_idle: assert property (p_req_idle) else $error("verdict without request");

  property p_ctx_pass;
    @(posedge i_clk) disable iff (i_rst)
    (i_req_valid && !i_req_ctx) |=> (o_req_done && o_req_accept);
  endproperty
  a_ctx_pass: assert property (p_ctx_pass) else $error("unfiltered context refused");

  property p_top_node;
    @(posedge i_clk) disable iff (i_rst)
    (i_req_valid && i_req_ctx && i_req_local_bus && i_req_node > NODE_LAST)
      |=> (o_req_done && !o_req_accept);
  endproperty
  a_top_node: assert property (p_top_node) else $error("unmapped node accepted");

  property p_ext_cycle;
    @(posedge i_clk) disable iff (i_rst)
    (quiet && st.ctrl.count_en && st.ctrl.ext_mode && i_ext_tick_8k && bus.time_val.cycles != CYCLE_LAST)
      |=> (bus.time_val.cycles == 13'($past(bus.time_val.cycles) + 13'h1));
  endproperty
  a_ext_cycle: assert property (p_ext_cycle) else $error("external tick lost cycle");

endmodule : ctrf_top

// ### test/ctrf_node_model.sv
// Remote bus node model issuing cycle starts and asynchronous requests
module ctrf_node_model (
  // Clock
  input  wire logic        i_clk,
  // Cycle start messages
  output logic             o_cs_valid,
  output logic      [31:0] o_cs_data,
  // Incoming requests
  output logic             o_req_valid,
  output logic             o_req_ctx,
  output logic             o_req_local_bus,
  output logic      [5:0]  o_req_node,
  output logic             o_req_low_accept
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_cs_valid       = 1'b0;
    o_cs_data        = 32'h0000_0000;
    o_req_valid      = 1'b0;
    o_req_ctx        = 1'b0;
    o_req_local_bus  = 1'b0;
    o_req_node       = 6'h00;
    o_req_low_accept = 1'b0;
  end

  // ========================================================================
  // Cycle start, one cycle, data scrambled once released
  task automatic send_cs(input logic [31:0] data);
    @(posedge i_clk);
    o_cs_valid <= 1'b1;
    o_cs_data  <= data;
    @(posedge i_clk);
    o_cs_valid <= 1'b0;
    o_cs_data  <= ~data;
  endtask : send_cs

  // ========================================================================
  // Request, qualifiers inverted after the taking edge
  task automatic send_req(input logic ctx, input logic local_bus, input logic [5:0] node,
                          input logic low);
    @(posedge i_clk);
    o_req_valid      <= 1'b1;
    o_req_ctx        <= ctx;
    o_req_local_bus  <= local_bus;
    o_req_node       <= node;
    o_req_low_accept <= low;
    @(posedge i_clk);
    o_req_valid      <= 1'b0;
    o_req_ctx        <= ~ctx;
    o_req_local_bus  <= ~local_bus;
    o_req_node       <= ~node;
    o_req_low_accept <= ~low;
  endtask : send_req
endmodule : ctrf_node_model

// ### test/ctrf_top_tb.sv
// Self-checking bench for the cycle timer and request filter
module ctrf_top_tb;
  import ctrf_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        i_clk;
  logic        i_rst;
  logic [11:0] i_addr;
  logic [31:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [31:0] o_rdata;
  logic        i_tick_24m;
  logic        i_ext_tick_8k;
  logic        i_cs_rx_valid;
  logic [31:0] i_cs_rx_data;
  logic        i_cs_tx_req;
  logic        o_cs_tx_valid;
  logic [31:0] o_cs_tx_data;
  logic        i_req_valid;
  logic        i_req_ctx;
  logic        i_req_local_bus;
  logic [5:0]  i_req_node;
  logic        i_req_low_accept;
  logic        o_req_done;
  logic        o_req_accept;
  int          n_mismatch;
  int          n_compared;

  ctrf_top ctrf_top_i (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_tick_24m(i_tick_24m),
    .i_ext_tick_8k(i_ext_tick_8k), .i_cs_rx_valid(i_cs_rx_valid), .i_cs_rx_data(i_cs_rx_data),
    .i_cs_tx_req(i_cs_tx_req), .o_cs_tx_valid(o_cs_tx_valid), .o_cs_tx_data(o_cs_tx_data),
    .i_req_valid(i_req_valid), .i_req_ctx(i_req_ctx), .i_req_local_bus(i_req_local_bus),
    .i_req_node(i_req_node), .i_req_low_accept(i_req_low_accept), .o_req_done(o_req_done),
    .o_req_accept(o_req_accept));

  ctrf_node_model ctrf_node_model_i (.i_clk(i_clk), .o_cs_valid(i_cs_rx_valid),
    .o_cs_data(i_cs_rx_data), .o_req_valid(i_req_valid), .o_req_ctx(i_req_ctx),
    .o_req_local_bus(i_req_local_bus), .o_req_node(i_req_node),
    .o_req_low_accept(i_req_low_accept));

  // ========================================================================
  // Clock and watchdog
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  initial begin
    repeat (5000) @(posedge i_clk);
    n_mismatch++;
    conclude();
  end

  // ========================================================================
  // Compare, bus and verdict tasks
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp32

  task automatic cmp1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp1

  task automatic wr(input logic [11:0] addr, input logic [31:0] data);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= addr;
    i_wdata <= data;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] addr, input logic [31:0] exp);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= addr;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    #1 cmp32(o_rdata, exp);
  endtask : rd

  task automatic req(input logic ctx, input logic loc, input logic [5:0] node, input logic low,
                     input logic exp);
    ctrf_node_model_i.send_req(ctx, loc, node, low);
    #1 cmp1(o_req_done, 1'b1);
    cmp1(o_req_accept, exp);
  endtask : req

  task automatic tx(input logic exp_valid, input logic [31:0] exp_data);
    @(posedge i_clk);
    i_cs_tx_req <= 1'b1;
    @(posedge i_clk);
    i_cs_tx_req <= 1'b0;
    #1 cmp1(o_cs_tx_valid, exp_valid);
    if (exp_valid) cmp32(o_cs_tx_data, exp_data);
  endtask : tx

  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  // ========================================================================
  // Test sequence
  initial begin
    n_mismatch    = 0;
    n_compared    = 0;
    i_rst         = 1'b1;
    i_addr        = 12'h000;
    i_wdata       = 32'h0000_0000;
    i_wr          = 1'b0;
    i_rd          = 1'b0;
    i_tick_24m    = 1'b0;
    i_ext_tick_8k = 1'b0;
    i_cs_tx_req   = 1'b0;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;

    rd(ADDR_SET, 32'h0000_0000); // set port reads zero
    rd(ADDR_CLR, 32'h0000_0000); // clear port reads zero
    req(1'b1, 1'b0, 6'h05, 1'b0, 1'b0); // remote rejected
    req(1'b1, 1'b1, 6'h3e, 1'b0, 1'b0); // upper node rejected
    rd(12'h0fc, 32'h0000_0000);
    $display("test reset done");

    wr(ADDR_SET, 32'h8000_0005); // set ones
    wr(ADDR_SET, 32'h0000_0002); // zeros keep bits
    rd(ADDR_SET, 32'h8000_0007); // read at set port
    wr(ADDR_CLR, 32'h0000_0005); // clear ones
    rd(ADDR_CLR, 32'h8000_0002); // read at clear port
    $display("test filter ports done");

    req(1'b1, 1'b1, 6'h21, 1'b0, 1'b1); // node 33 via bit 1
    req(1'b1, 1'b1, 6'h20, 1'b1, 1'b0); // node 32 bit zero
    req(1'b1, 1'b0, 6'h20, 1'b0, 1'b1); // remote accepted
    req(1'b1, 1'b0, 6'h21, 1'b0, 1'b1); // no per-node check off bus
    req(1'b0, 1'b1, 6'h20, 1'b0, 1'b1); // other context untouched
    req(1'b1, 1'b1, 6'h05, 1'b1, 1'b1); // low node verdict
    req(1'b1, 1'b1, 6'h3f, 1'b1, 1'b0);
    wr(ADDR_SET, 32'h4000_0000);
    req(1'b1, 1'b1, 6'h3e, 1'b0, 1'b1); // node 62 via bit 30
    wr(ADDR_CLR, 32'h8000_0000);
    req(1'b1, 1'b0, 6'h20, 1'b0, 1'b0); // remote rejected again
    $display("test request filter done");

    wr(ADDR_CTRL, 32'h0000_0002);
    wr(ADDR_TIMER, 32'hfff3_fbfe); // software write
    rd(ADDR_TIMER, 32'hfff3_fbfe); // read back
    @(posedge i_clk);
    i_tick_24m <= 1'b1;
    @(posedge i_clk);
    i_tick_24m <= 1'b0;
    rd(ADDR_TIMER, 32'hfff3_fbff); // tick advance
    @(posedge i_clk);
    i_tick_24m <= 1'b1;
    @(posedge i_clk);
    i_tick_24m <= 1'b0;
    rd(ADDR_TIMER, 32'h0000_0000); // all fields wrap
    wr(ADDR_TIMER, 32'h0000_0bff);
    @(posedge i_clk);
    i_tick_24m <= 1'b1;
    @(posedge i_clk);
    i_tick_24m <= 1'b0;
    rd(ADDR_TIMER, 32'h0000_1000); // cycle advance on wrap
    wr(ADDR_CTRL, 32'h0000_0000);
    @(posedge i_clk);
    i_tick_24m <= 1'b1;
    @(posedge i_clk);
    i_tick_24m <= 1'b0;
    rd(ADDR_TIMER, 32'h0000_1000); // no count when disabled
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= ADDR_TIMER;
    i_wdata <= 32'h0246_8ace;
    @(posedge i_clk);
    i_wr    <= 1'b0;
    i_rd    <= 1'b1;
    @(posedge i_clk);
    i_rd    <= 1'b0;
    #1 cmp32(o_rdata, 32'h0246_8ace); // back-to-back read
    $display("test counting done");

    wr(ADDR_CTRL, 32'h0000_0006);
    rd(ADDR_CTRL, 32'h0000_0006);
    wr(ADDR_TIMER, 32'h0000_1100);
    @(posedge i_clk);
    i_ext_tick_8k <= 1'b1;
    @(posedge i_clk);
    i_ext_tick_8k <= 1'b0;
    rd(ADDR_TIMER, 32'h0000_2000); // external tick clears ticks
    $display("test external tick done");

    wr(ADDR_CTRL, 32'h0000_0000);
    ctrf_node_model_i.send_cs(32'h1234_5678);
    rd(ADDR_TIMER, 32'h1234_5678); // load from cycle start
    tx(1'b0, 32'h0000_0000); // no send when not master
    wr(ADDR_CTRL, 32'h0000_0001);
    ctrf_node_model_i.send_cs(32'h0abc_d123);
    rd(ADDR_TIMER, 32'h1234_5678); // master ignores cycle start
    tx(1'b1, 32'h1234_5678); // timer sent as master
    tx(1'b1, 32'h1234_5678); // repeat request
    $display("test cycle start done");

    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(ADDR_SET, FILTER_RST); // filter cleared by reset
    req(1'b1, 1'b1, 6'h3e, 1'b0, 1'b0); // node 62 rejected again
    rd(ADDR_CTRL, 32'h0000_0000);
    $display("test second reset done");
    conclude();
  end
endmodule : ctrf_top_tb
